// ==== hdl/amc_regs.svh ====
// constants and timing counts for the amplifier mode, mute and diagnostic control
// Behaviour
// - ac-load detection uses high current mode when the mode bit is 1, else low.
// - enabling ac-load detection clears the peak counter and starts a new measurement.
// - a channel's ac-load bit sets only after four threshold crossings.
// - ac-load detection runs only after start-up completes with best efficiency off.
// - view bit 1 shows ac-load results on ac_result_r; view 0 hides but keeps them.
// - distortion above the 2, 5 or 10 percent threshold asserts the routed pin.
// - clip level 00 is 2, 01 is 5, 10 is 10 percent, 11 disables.
// - each channel's clip indication routes separately to diagnostic or standby pin.
// - disabling temperature and load reporting leaves only clip on the diagnostic pin; the code also drives it from por_flag_r until amplifier start.
// - clip indications blocked below 10 V unless low-voltage clip enable is set.
// - separate gain bits for front and rear pairs; special modes need 16 dB.
// - bias 0.23 of supply only with both pairs 16 dB and line driver, else 0.5.
// - shorted address-select pin means legacy mode; otherwise bus mode at resistor address.
// - address latched while supply is below 6 V; invalid until supply first rises above 6 V.
// - legacy standby pin is off, mute or operate; unmute release timed 15 ms.
// - operate to off after start applies hard mute within 400 us, then shuts down.
// - bus mode standby low idles; raising it resets and pulls diagnostic pin low.
// - amplifier-start bit starts amp, clears reset-occurred flag, releases diagnostic pin.
// - soft mute applies per front or rear pair, ramp completes in 15 ms.
// - hard mute mutes all within 400 us; release is a 15 ms soft unmute.
// - each diagnostic latch sets on failure and holds until cleared by a read.
// - latches clear only after all five data bytes are read; four leaves them.
// - diagnostic pin follows live faults and releases at once, ignoring latches.
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH
`define AMC_CLK_MHZ        100
`define AMC_SOFT_MUTE_US   15000
`define AMC_HARD_MUTE_US   400
`define AMC_SOFT_CYC       (`AMC_SOFT_MUTE_US * `AMC_CLK_MHZ)
`define AMC_HARD_CYC       (`AMC_HARD_MUTE_US * `AMC_CLK_MHZ)
`define AMC_AC_CROSSINGS   4
`define AMC_READ_BYTES     5
`define AMC_CLIP_2PCT      2'h0
`define AMC_CLIP_5PCT      2'h1
`define AMC_CLIP_10PCT     2'h2
`define AMC_CLIP_OFF       2'h3
`define AMC_AC_BIT         4
`define AMC_POR_BIT        7
`define AMC_LAT_W          8
`endif

// ==== hdl/amc_pkg.sv ====
// types for the amplifier mode, mute and diagnostic control
package amc_pkg;
    typedef enum logic [3:0] {
        ST_OFF   = 4'b0001,
        ST_MUTE  = 4'b0010,
        ST_OPER  = 4'b0100,
        ST_HMUTE = 4'b1000
    } amc_state_t;

    typedef struct packed {
        logic       low_v_clip;   // clip allowed below 10 V
        logic [3:0] clip_to_stb;  // per channel route, 1 = standby pin
        logic       ac_en;
        logic       amp_start;
        logic [1:0] clip_level;
        logic       no_temp_diag;
        logic       no_load_diag;
        logic       soft_mute_f;
        logic       soft_mute_r;
        logic       hard_mute;
        logic       gain16_f;
        logic       gain16_r;
        logic       line_drv;
        logic       ac_view;
        logic       ac_high_cur;
        logic       best_eff;
    } amc_ctrl_t;

    typedef struct packed {
        logic [3:0] clip;      // per channel distortion over threshold
        logic [3:0] ac_cross;  // per channel peak-threshold crossing pulse
        logic [3:0] short_f;   // per channel load short
        logic       temp_warn;
        logic       sup_ok10;  // supply above 10 V
        logic       sup_ok6;   // supply above 6 V
        logic       startup_done;
    } amc_sense_t;
endpackage

// ==== hdl/amc_ctrl.sv ====
// amplifier mode, mute sequencing, clip routing and diagnostic latch control
`timescale 1ns/1ns
`include "amc_regs.svh"
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int SOFT_CYC = `AMC_SOFT_CYC,
    parameter int HARD_CYC = `AMC_HARD_CYC
) (
    // system
    input  wire logic       mclk,
    input  wire logic       rst,
    // bus side clock domain
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       rd_byte_done,
    // control and sensing
    input  wire amc_ctrl_t  ctrl,
    input  wire amc_sense_t sense,
    input  wire logic [2:0] addr_code,
    input  wire logic       addr_shorted,
    input  wire logic [1:0] standby_pin,
    // outputs
    output logic            legacy_r,
    output logic [2:0]      addr_r,
    output logic            addr_valid_r,
    output logic            amp_on_r,
    output logic            mute_f_r,
    output logic            mute_r_r,
    output logic            bias_low_r,
    output logic            ac_high_r,
    output logic            diag_pin_r,
    output logic            stb_clip_r,
    output logic [3:0]      ac_result_r,
    output logic [7:0]      status_byte_r,
    output logic            por_flag_r
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] stb_s1, stb_s2;
    logic [2:0] addr_s1, addr_s2;
    logic       sh_s1, sh_s2, ok6_s1, ok6_s2;
    always_ff @(posedge mclk) begin
        stb_s1 <= standby_pin;
        stb_s2 <= stb_s1;
        sh_s1  <= addr_shorted;
        sh_s2  <= sh_s1;
        ok6_s1 <= sense.sup_ok6;
        ok6_s2 <= ok6_s1;
        // same depth as the supply flag, so a code change with a drop is not caught
        addr_s1 <= addr_code;
        addr_s2 <= addr_s1;
    end

    // ------------------------------------------------------------
    // read-complete crossing from the bus clock
    // ------------------------------------------------------------
    logic [2:0] byte_cnt_r;
    logic       rd_tgl_r;
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            byte_cnt_r <= 3'h0;
            rd_tgl_r   <= 1'b0;
        end else if (rd_byte_done) begin
            if (byte_cnt_r == 3'(`AMC_READ_BYTES - 1)) begin
                byte_cnt_r <= 3'h0;
                rd_tgl_r   <= ~rd_tgl_r;
            end else begin
                byte_cnt_r <= byte_cnt_r + 3'h1;
            end
        end
    end
    logic t_s1, t_s2, t_s3;
    always_ff @(posedge mclk) begin
        if (rst) begin
            t_s1 <= 1'b0;
            t_s2 <= 1'b0;
            t_s3 <= 1'b0;
        end else begin
            t_s1 <= rd_tgl_r;
            t_s2 <= t_s1;
            t_s3 <= t_s2;
        end
    end
    logic rd_clear;
    assign rd_clear = t_s2 ^ t_s3;

    // ------------------------------------------------------------
    // address latch and mode
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            legacy_r     <= 1'b0;
            addr_r       <= 3'h0;
            addr_valid_r <= 1'b0;
        end else begin
            legacy_r <= sh_s2;
            if (ok6_s2) begin
                addr_r       <= addr_s2;
                addr_valid_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // standby sequencing and mute timing
    // ------------------------------------------------------------
    amc_state_t st_r, st_nxt;
    logic [31:0] tmr_r;
    logic        stb_off, stb_mute, run_req;
    assign stb_off  = (stb_s2 == 2'h0);
    assign stb_mute = (stb_s2 == 2'h1);
    assign run_req  = legacy_r ? !stb_off : (!stb_off && ctrl.amp_start);
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF:   st_nxt = run_req ? ST_MUTE : ST_OFF;
            ST_MUTE: begin
                if (!run_req) st_nxt = ST_OFF;
                else if (!(legacy_r && stb_mute) && tmr_r >= 32'(SOFT_CYC)) st_nxt = ST_OPER;
            end
            ST_OPER:  st_nxt = !run_req ? ST_HMUTE : (legacy_r && stb_mute) ? ST_MUTE : ST_OPER;
            ST_HMUTE: st_nxt = (tmr_r >= 32'(HARD_CYC)) ? ST_OFF : ST_HMUTE;
            default:  st_nxt = ST_OFF;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r  <= ST_OFF;
            tmr_r <= 32'h0;
        end else begin
            st_r  <= st_nxt;
            tmr_r <= (st_nxt != st_r) ? 32'h0 : tmr_r + 32'h1;
        end
    end
    // soft mute ramps per pair; hard mute immediate, unmute soft
    logic [31:0] rf_r, rr_r;
    logic        hm;
    assign hm = ctrl.hard_mute || st_r != ST_OPER;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rf_r     <= 32'h0;
            rr_r     <= 32'h0;
            mute_f_r <= 1'b1;
            mute_r_r <= 1'b1;
            amp_on_r <= 1'b0;
        end else begin
            amp_on_r <= (st_r != ST_OFF);
            if (hm) begin
                rf_r <= 32'h0;
                rr_r <= 32'h0;
            end else begin
                rf_r <= ctrl.soft_mute_f ? 32'h0 :
                        (rf_r < 32'(SOFT_CYC)) ? rf_r + 32'h1 : rf_r;
                rr_r <= ctrl.soft_mute_r ? 32'h0 :
                        (rr_r < 32'(SOFT_CYC)) ? rr_r + 32'h1 : rr_r;
            end
            mute_f_r <= hm || rf_r < 32'(SOFT_CYC);
            mute_r_r <= hm || rr_r < 32'(SOFT_CYC);
        end
    end

    // ------------------------------------------------------------
    // gain and bias
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            bias_low_r <= 1'b0;
            ac_high_r  <= 1'b0;
        end else begin
            bias_low_r <= ctrl.gain16_f && ctrl.gain16_r && ctrl.line_drv;
            ac_high_r  <= ctrl.ac_high_cur;
        end
    end

    // ------------------------------------------------------------
    // clip routing and diagnostic pin
    // ------------------------------------------------------------
    logic [3:0] clip_ok;
    logic       fault_live;
    assign clip_ok = (ctrl.clip_level != `AMC_CLIP_OFF &&
                      (sense.sup_ok10 || ctrl.low_v_clip)) ? sense.clip : 4'h0;
    assign fault_live = (!ctrl.no_temp_diag && sense.temp_warn) ||
                        (!ctrl.no_load_diag && |sense.short_f);
    always_ff @(posedge mclk) begin
        if (rst) begin
            diag_pin_r <= 1'b0;
            stb_clip_r <= 1'b0;
        end else begin
            diag_pin_r <= por_flag_r || fault_live || |(clip_ok & ~ctrl.clip_to_stb);
            stb_clip_r <= |(clip_ok & ctrl.clip_to_stb);
        end
    end

    // ------------------------------------------------------------
    // power-on flag
    // ------------------------------------------------------------
    logic on_prev_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            por_flag_r <= 1'b1;
            on_prev_r  <= 1'b0;
        end else begin
            on_prev_r <= !stb_off;
            if (!stb_off && !on_prev_r && !legacy_r) por_flag_r <= 1'b1;
            else if (ctrl.amp_start) por_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // ac-load detection
    // ------------------------------------------------------------
    logic [2:0] cnt_r [4];
    logic [3:0] ac_r;
    logic       ac_en_d, ac_run;
    assign ac_run = ctrl.ac_en && sense.startup_done && !ctrl.best_eff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ac_en_d <= 1'b0;
            ac_r    <= 4'h0;
            for (int i = 0; i < 4; i++) cnt_r[i] <= 3'h0;
        end else begin
            ac_en_d <= ctrl.ac_en;
            for (int i = 0; i < 4; i++) begin
                if (ctrl.ac_en && !ac_en_d) begin
                    cnt_r[i] <= 3'h0;
                    ac_r[i]  <= 1'b0;
                end else if (ac_run && sense.ac_cross[i] &&
                             cnt_r[i] < 3'(`AMC_AC_CROSSINGS)) begin
                    cnt_r[i] <= cnt_r[i] + 3'h1;
                    if (cnt_r[i] == 3'(`AMC_AC_CROSSINGS - 1)) ac_r[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // diagnostic latches, cleared after full read
    // ------------------------------------------------------------
    logic [7:0] lat_r, ev;
    assign ev = {3'h0, sense.temp_warn, sense.short_f};
    always_ff @(posedge mclk) begin
        if (rst) lat_r <= 8'h0;
        else lat_r <= (rd_clear ? 8'h0 : lat_r) | ev;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_byte_r <= 8'h0;
            ac_result_r   <= 4'h0;
        end else begin
            status_byte_r <= lat_r;
            ac_result_r   <= ctrl.ac_view ? ac_r : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ac_hidden;
        @(posedge mclk) disable iff (rst) !ctrl.ac_view |=> ac_result_r == 4'h0;
    endproperty
    a_ac_hidden: assert property (p_ac_hidden) else $error("ac result shown while hidden");
    property p_bias;
        @(posedge mclk) disable iff (rst)
        (ctrl.gain16_f && ctrl.gain16_r && ctrl.line_drv) |=> bias_low_r;
    endproperty
    a_bias: assert property (p_bias) else $error("low bias not set");
    property p_latch_hold;
        @(posedge mclk) disable iff (rst) (|lat_r && !rd_clear) |=> (lat_r & $past(lat_r)) == $past(lat_r);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost without read");
    property p_event_kept;
        @(posedge mclk) disable iff (rst) (rd_clear && ev[0]) |=> lat_r[0];
    endproperty
    a_event_kept: assert property (p_event_kept) else $error("event lost in clear");
    property p_stb_route;
        @(posedge mclk) disable iff (rst) |(clip_ok & ctrl.clip_to_stb) |=> stb_clip_r;
    endproperty
    a_stb_route: assert property (p_stb_route) else $error("clip not on standby");
    property p_clip_off;
        @(posedge mclk) disable iff (rst)
        (ctrl.clip_level == `AMC_CLIP_OFF) |=> !stb_clip_r;
    endproperty
    a_clip_off: assert property (p_clip_off) else $error("clip shown while disabled");
    property p_hard_off;
        @(posedge mclk) disable iff (rst) (st_r == ST_HMUTE) |-> mute_f_r || $past(st_r) == ST_OPER;
    endproperty
    a_hard_off: assert property (p_hard_off) else $error("not muted in shutdown");
    property p_por_clear;
        @(posedge mclk) disable iff (rst) (ctrl.amp_start && !(!stb_off && !on_prev_r)) |=> !por_flag_r;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("reset flag not cleared");
endmodule

// ==== verification/amc_host_model.sv ====
// bus master model that completes read bytes on the link clock
`timescale 1ns/1ns
module amc_host_model (
    // link side
    input  wire logic link_clk,
    input  wire logic link_rst,
    output logic      rd_byte_done
);
    initial rd_byte_done = 1'b0;
    // one pulse a byte; gap cycles stand for the byte time, so fast or slow
    task automatic read_bytes(input int n, input int gap);
        while (link_rst) @(posedge link_clk);
        repeat (n) begin
            @(posedge link_clk);
            rd_byte_done <= 1'b1;
            @(posedge link_clk);
            rd_byte_done <= 1'b0;
            repeat (gap) @(posedge link_clk);
        end
    endtask
endmodule

// ==== verification/amp_mode_mute_diag_control_tb_top.sv ====
// self-checking bench for the mode, mute and diagnostic control
`timescale 1ns/1ns
module amp_mode_mute_diag_control_tb_top;
    import amc_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
    logic rd_byte_done, addr_shorted = 1'b0;
    logic [2:0] addr_code = 3'h5;
    logic [1:0] standby_pin = 2'h2;
    amc_ctrl_t ctrl = '0;
    amc_sense_t sense = '0;
    logic legacy_r, addr_valid_r, amp_on_r, mute_f_r, mute_r_r, bias_low_r, ac_high_r;
    logic diag_pin_r, stb_clip_r, por_flag_r;
    logic [2:0] addr_r;
    logic [3:0] ac_result_r;
    logic [7:0] status_byte_r;
    int n_fail = 0, tests_run = 0, cyc = 0;
    always #5 mclk = ~mclk;
    initial begin
        #2;
        forever #3 link_clk = ~link_clk;
    end
    amc_ctrl #(.SOFT_CYC(50), .HARD_CYC(10)) i_dut (
        .mclk(mclk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
        .rd_byte_done(rd_byte_done), .ctrl(ctrl), .sense(sense), .addr_code(addr_code),
        .addr_shorted(addr_shorted), .standby_pin(standby_pin), .legacy_r(legacy_r),
        .addr_r(addr_r), .addr_valid_r(addr_valid_r), .amp_on_r(amp_on_r),
        .mute_f_r(mute_f_r), .mute_r_r(mute_r_r), .bias_low_r(bias_low_r),
        .ac_high_r(ac_high_r), .diag_pin_r(diag_pin_r), .stb_clip_r(stb_clip_r),
        .ac_result_r(ac_result_r), .status_byte_r(status_byte_r), .por_flag_r(por_flag_r)
    );
    amc_host_model i_host (.link_clk(link_clk), .link_rst(link_rst),
        .rd_byte_done(rd_byte_done));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ac_pulses(input int n);
        repeat (n) begin
            sense.ac_cross = 4'hF;
            step(1);
            sense.ac_cross = 4'h0;
            step(1);
        end
        step(2);
    endtask
    // cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        sense.sup_ok10 = 1'b1;
        sense.sup_ok6 = 1'b1;
        sense.startup_done = 1'b1;
        step(6);
        rst = 1'b0;
        link_rst = 1'b0;
        step(1);
        check({mute_f_r, mute_r_r, por_flag_r}, 8'h07);
        step(1);
        check(diag_pin_r, 1'b1);
        step(2);
        check({addr_valid_r, addr_r}, 8'h0D);
        sense.sup_ok6 = 1'b0;
        addr_code = 3'h2;
        step(4);
        check(addr_r, 3'h5);
        sense.sup_ok6 = 1'b1;
        ctrl.amp_start = 1'b1;
        step(3);
        check({amp_on_r, por_flag_r, diag_pin_r}, 8'h04);
        for (int i = 0; i < 8; i++) begin
            {ctrl.gain16_f, ctrl.gain16_r, ctrl.line_drv} = 3'(i);
            step(2);
            check(bias_low_r, (i == 7));
        end
        ctrl.ac_high_cur = 1'b1;
        step(2);
        check(ac_high_r, 1'b1);
        ctrl.ac_high_cur = 1'b0;
        step(2);
        check(ac_high_r, 1'b0);
        // live short drives the pin, latch holds until a full read
        sense.short_f = 4'h2;
        step(3);
        check(diag_pin_r, 1'b1);
        sense.short_f = 4'h0;
        step(2);
        check(diag_pin_r, 1'b0);
        check(status_byte_r, 8'h02);
        i_host.read_bytes(5, 3);
        step(8);
        check(status_byte_r, 8'h00);
        ctrl.no_temp_diag = 1'b1;
        sense.temp_warn = 1'b1;
        step(3);
        check(diag_pin_r, 1'b0);
        sense.temp_warn = 1'b0;
        step(2);
        check(status_byte_r, 8'h10);
        i_host.read_bytes(4, 0);
        step(8);
        check(status_byte_r, 8'h10);
        i_host.read_bytes(1, 0);
        step(8);
        check(status_byte_r, 8'h00);
        // short held across the clear survives, a gone one is dropped
        sense.short_f = 4'h3;
        step(2);
        sense.short_f = 4'h1;
        i_host.read_bytes(5, 0);
        step(6);
        sense.short_f = 4'h0;
        step(4);
        check(status_byte_r, 8'h01);
        ctrl.ac_view = 1'b1;
        ctrl.ac_en = 1'b1;
        step(2);
        ac_pulses(3);
        check(ac_result_r, 4'h0);
        ac_pulses(1);
        check(ac_result_r, 4'hF);
        ctrl.ac_view = 1'b0;
        step(2);
        check(ac_result_r, 4'h0);
        ctrl.ac_view = 1'b1;
        step(2);
        check(ac_result_r, 4'hF);
        ctrl.ac_en = 1'b0;
        ctrl.best_eff = 1'b1;
        step(2);
        ctrl.ac_en = 1'b1;
        step(2);
        ac_pulses(4);
        check(ac_result_r, 4'h0);
        ctrl.best_eff = 1'b0;
        ctrl.clip_to_stb = 4'h1;
        sense.clip = 4'h1;
        for (int lv = 0; lv < 4; lv++) begin
            ctrl.clip_level = 2'(lv);
            step(2);
            check(stb_clip_r, (lv != 3));
        end
        ctrl.clip_level = 2'h1;
        sense.sup_ok10 = 1'b0;
        step(2);
        check(stb_clip_r, 1'b0);
        ctrl.low_v_clip = 1'b1;
        step(2);
        check(stb_clip_r, 1'b1);
        ctrl.clip_to_stb = 4'h0;
        step(2);
        check({stb_clip_r, diag_pin_r}, 8'h01);
        sense.clip = 4'h0;
        check({mute_f_r, mute_r_r}, 8'h00);
        ctrl.soft_mute_f = 1'b1;
        step(2);
        check({mute_f_r, mute_r_r}, 8'h02);
        ctrl.soft_mute_f = 1'b0;
        ctrl.soft_mute_r = 1'b1;
        step(2);
        check({mute_f_r, mute_r_r}, 8'h03);
        step(55);
        check({mute_f_r, mute_r_r}, 8'h01);
        ctrl.soft_mute_r = 1'b0;
        ctrl.hard_mute = 1'b1;
        step(2);
        check({mute_f_r, mute_r_r}, 8'h03);
        ctrl.hard_mute = 1'b0;
        step(30);
        check({mute_f_r, mute_r_r}, 8'h03);
        step(25);
        check({mute_f_r, mute_r_r}, 8'h00);
        ctrl = '0;
        standby_pin = 2'h0;
        addr_shorted = 1'b1;
        step(16);
        check({legacy_r, amp_on_r}, 8'h02);
        standby_pin = 2'h2;
        step(6);
        check({amp_on_r, mute_f_r}, 8'h03);
        step(110);
        check({mute_f_r, mute_r_r}, 8'h00);
        // plop-free shutdown: mute held long before off
        standby_pin = 2'h1;
        step(5);
        check({amp_on_r, mute_f_r}, 8'h03);
        step(170);
        standby_pin = 2'h0;
        step(5);
        check(amp_on_r, 1'b0);
        standby_pin = 2'h2;
        step(120);
        check({amp_on_r, mute_f_r}, 8'h02);
        standby_pin = 2'h0;
        step(5);
        check({mute_f_r, mute_r_r}, 8'h03);
        step(20);
        check(amp_on_r, 1'b0);
        wrap_up();
    end
endmodule
